// File: sfe_card_model.sv
// partner model: card that answers an interrogation after a set delay
`timescale 1ns/100ps
`default_nettype none
module sfe_card_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // interrogation handshake
  input wire logic interrogate_start,
  input wire logic [3:0] delay,
  input wire sfe_pkg::sfe_state_t card_id,
  output logic interrogate_done,
  output sfe_pkg::sfe_state_t interrogate_result
);
  logic [4:0] cnt_r; // cycles left before the answer
  // countdown from the start pulse, done lasts one cycle
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= 5'h00;
      interrogate_done <= 1'b0;
    end else begin
      interrogate_done <= (cnt_r == 5'h01);
      if (interrogate_start) cnt_r <= {1'b0, delay} + 5'h01;
      else if (cnt_r != 5'h00) cnt_r <= cnt_r - 5'h01;
    end
  end
  // outside done show the inverse, so a stale sample is caught
  assign interrogate_result = interrogate_done ? card_id : ~card_id;
endmodule : sfe_card_model
`default_nettype wire

// File: sfe_pkg.sv
// package: offsets, field positions and types for the socket force/control block
package sfe_pkg;
  // register offsets within socket space
  localparam logic [7:0] SFE_OFF_INJECT = 8'h0C;
  localparam logic [7:0] SFE_OFF_CTRL = 8'h10;
  // reset values
  localparam logic [31:0] SFE_INJECT_RST = 32'h0000_0000;
  localparam logic [7:0] SFE_CTRL_RST = 8'h00;
  // injection field positions
  localparam int SFE_B_REINT = 14;
  localparam int SFE_B_VY = 13;
  localparam int SFE_B_VL = 10;
  localparam int SFE_B_BADV = 9;
  localparam int SFE_B_LOSS = 8;
  localparam int SFE_B_UNREC = 7;
  localparam int SFE_B_CB = 5;
  localparam int SFE_B_NARROW = 4;
  localparam int SFE_B_PWR = 3;
  localparam int SFE_B_CSTS = 0;
  // control field positions
  localparam int SFE_B_STOP = 7;
  localparam int SFE_B_VCC_HI = 6;
  localparam int SFE_B_VCC_LO = 4;
  localparam int SFE_B_VPP_HI = 2;
  localparam int SFE_B_VPP_LO = 0;
  localparam int SFE_B_CTRL_RSVD = 3;
  // vcc request codes
  localparam logic [2:0] SFE_VCC_OFF = 3'h0;
  localparam logic [2:0] SFE_VCC_HIGH = 3'h2;
  localparam logic [2:0] SFE_VCC_LOW = 3'h3;
  localparam logic [2:0] SFE_VCC_X = 3'h4;
  localparam logic [2:0] SFE_VCC_Y = 3'h5;
  // control writable mask: bits 7..4 and 2..0
  localparam logic [7:0] SFE_CTRL_WMASK = 8'hF7;
  // present-state fields driven by the injection register
  typedef struct packed {
    logic [3:0] volt_support;     // y, x, low, high
    logic invalid_voltage_request_flag;
    logic possible_data_loss_flag;
    logic unrecognized_card_flag;
    logic cardbus_detected_flag;
    logic narrow_card_detected_flag;
  } sfe_state_t;
  // event flags written through the injection register
  typedef struct packed {
    logic power_event_flag;
    logic detect_two_event_flag;
    logic detect_one_event_flag;
    logic status_change_event_flag;
  } sfe_event_t;
endpackage : sfe_pkg

// File: sfe_socket_force_event_and_control_test.sv
// testbench: socket injection and control registers against a card model
`timescale 1ns/100ps
`default_nettype none
module sfe_socket_force_event_and_control_test;
  logic sys_clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic socket_idle = 1'b1, host_clk_stopping = 1'b0; // clock policy inputs
  logic clk_en = 1'b1; // freeze control
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, rdata, rd_v;
  logic [3:0] delay = 4'h0; // card answer delay
  sfe_pkg::sfe_state_t card_id = 9'h022, res, pst; // cardbus, high voltage only
  sfe_pkg::sfe_event_t ev;
  logic start, done, ev_ld, pwr_en, allowed, stop_ok;
  logic [2:0] vcc, vpp;
  int err_count = 0, cmp_count = 0;
  logic [31:0] pat [3] = '{32'hFFFF_BFFF, 32'h0000_2A95, 32'h0000_016A};
  logic [3:0] cs [4] = '{4'b0100, 4'b0111, 4'b1101, 4'b1000}; // stop,idle,hstop,exp
  sfe_socket_regs sfe_socket_regs_inst (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(rdata), .interrogate_start(start), .interrogate_done(done),
    .interrogate_result(res), .present_state(pst), .event_load(ev_ld), .event_value(ev),
    .power_ctrl_enable(pwr_en), .vcc_request(vcc), .vpp_request(vpp),
    .vcc_request_allowed(allowed), .socket_idle(socket_idle),
    .host_clk_stopping(host_clk_stopping), .card_clk_stop_allowed(stop_ok));
  sfe_card_model sfe_card_model_inst (.sys_clk(sys_clk), .rst_b(rst_b),
    .interrogate_start(start), .delay(delay), .card_id(card_id),
    .interrogate_done(done), .interrogate_result(res));
  // ********************
  // tasks
  // ********************
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // strobe held for exactly one taken edge
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr
  task rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    #1 rd_v = rdata;
  endtask : rd
  task test_done;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done
  // ********************
  // stimulus
  // ********************
  initial forever #2.5 sys_clk = ~sys_clk;
  // watchdog: whole run is about a hundred cycles
  initial begin
    repeat (3000) @(posedge sys_clk);
    err_count++;
    test_done;
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    #1 chk("power_en", pwr_en, 1);
    rd(sfe_pkg::SFE_OFF_INJECT); chk("inject", rd_v, sfe_pkg::SFE_INJECT_RST);
    rd(sfe_pkg::SFE_OFF_CTRL); chk("ctrl", rd_v, 0);
    wr(8'h14, 32'hFFFF_FFFF); rd(8'h14); chk("unmapped", rd_v, 0);
    $display("test reset done");
    foreach (pat[i]) begin
      wr(sfe_pkg::SFE_OFF_INJECT, pat[i]);
      chk("state", pst, {pat[i][13:7], pat[i][5:4]});
      chk("ev_load", ev_ld, 1);
      chk("ev", ev, pat[i][3:0]);
      if (i == 0) chk("power_en", pwr_en, 0);
      rd(sfe_pkg::SFE_OFF_INJECT); chk("inject", rd_v, 0);
      chk("ev_load", ev_ld, 0);
    end
    $display("test inject done");
    // prompt card, then slow card
    for (int k = 0; k < 2; k++) begin
      delay <= k ? 4'h9 : 4'h0;
      wr(sfe_pkg::SFE_OFF_INJECT, 32'h0000_4000);
      chk("start", start, 1);
      for (int n = 0; n < 20 && !done; n++) @(posedge sys_clk) #1;
      @(posedge sys_clk);
      #1 chk("state", pst, card_id);
      chk("power_en", pwr_en, 1);
    end
    $display("test reinterrogate done");
    wr(sfe_pkg::SFE_OFF_CTRL, 32'hFFFF_FFFF); rd(sfe_pkg::SFE_OFF_CTRL);
    chk("ctrl", rd_v, {24'h0, sfe_pkg::SFE_CTRL_WMASK});
    wr(sfe_pkg::SFE_OFF_CTRL, 32'h23);
    repeat (2) @(posedge sys_clk);
    #1 chk("vcc", {allowed, vcc, vpp}, 7'h53);
    wr(sfe_pkg::SFE_OFF_CTRL, 32'h30);
    repeat (2) @(posedge sys_clk);
    #1 chk("vcc", {allowed, vcc}, 0);
    foreach (cs[j]) begin
      wr(sfe_pkg::SFE_OFF_CTRL, {24'h0, cs[j][3], 7'h0});
      socket_idle <= cs[j][2];
      host_clk_stopping <= cs[j][1];
      repeat (2) @(posedge sys_clk);
      #1 chk("stop_ok", stop_ok, cs[j][0]);
    end
    $display("test control done");
    // clock enable low: a control write must not land
    clk_en <= 1'b0;
    wr(sfe_pkg::SFE_OFF_CTRL, 32'h0000_0011);
    clk_en <= 1'b1;
    rd(sfe_pkg::SFE_OFF_CTRL); chk("frozen", rd_v, 32'h0000_0080);
    $display("test freeze done");
    test_done;
  end
endmodule : sfe_socket_force_event_and_control_test
`default_nettype wire

// File: sfe_socket_regs.sv
// module: socket event injection and power/clock control registers
`timescale 1ns/100ps
`default_nettype none

module sfe_socket_regs (
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  // card interrogation handshake
  output logic interrogate_start,
  input wire logic interrogate_done,
  input wire sfe_pkg::sfe_state_t interrogate_result,
  // socket status to present-state and event logic
  output sfe_pkg::sfe_state_t present_state,
  output logic event_load,
  output sfe_pkg::sfe_event_t event_value,
  // socket power and clock policy
  output logic power_ctrl_enable,
  output logic [2:0] vcc_request,
  output logic [2:0] vpp_request,
  output logic vcc_request_allowed,
  input wire logic socket_idle,
  input wire logic host_clk_stopping,
  output logic card_clk_stop_allowed
);

  // ********************************
  // decode
  // ********************************
  logic wr_inject;
  logic wr_ctrl;
  logic [7:0] ctrl_r;
  logic busy_r;
  assign wr_inject = clk_en && reg_wr && (reg_addr == sfe_pkg::SFE_OFF_INJECT);
  assign wr_ctrl = clk_en && reg_wr && (reg_addr == sfe_pkg::SFE_OFF_CTRL);

  // ********************************
  // readback
  // ********************************
  // injection register holds no readable state, so it always reads zero
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 32'h0000_0000;
    end else if (clk_en && reg_rd) begin
      if (reg_addr == sfe_pkg::SFE_OFF_CTRL) begin
        reg_rdata <= {24'h00_0000, ctrl_r};
      end else begin
        reg_rdata <= sfe_pkg::SFE_INJECT_RST;
      end
    end
  end

  // ********************************
  // present-state injection and interrogation
  // ********************************
  // injected writes take priority over a finishing probe in the same cycle
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      present_state <= '0;
      power_ctrl_enable <= 1'b1;
      interrogate_start <= 1'b0;
      busy_r <= 1'b0;
    end else if (clk_en) begin
      interrogate_start <= 1'b0;
      if (wr_inject) begin
        present_state.volt_support <= reg_wdata[sfe_pkg::SFE_B_VY:sfe_pkg::SFE_B_VL];
        present_state.invalid_voltage_request_flag <= reg_wdata[sfe_pkg::SFE_B_BADV];
        present_state.possible_data_loss_flag <= reg_wdata[sfe_pkg::SFE_B_LOSS];
        present_state.unrecognized_card_flag <= reg_wdata[sfe_pkg::SFE_B_UNREC];
        present_state.cardbus_detected_flag <= reg_wdata[sfe_pkg::SFE_B_CB];
        present_state.narrow_card_detected_flag <= reg_wdata[sfe_pkg::SFE_B_NARROW];
        if (reg_wdata[sfe_pkg::SFE_B_REINT]) begin
          interrogate_start <= 1'b1;
          busy_r <= 1'b1;
        end
        if (|reg_wdata[sfe_pkg::SFE_B_VY:sfe_pkg::SFE_B_VL]) begin
          power_ctrl_enable <= 1'b0;
        end
      end else if (busy_r && interrogate_done) begin
        present_state <= interrogate_result;
        power_ctrl_enable <= 1'b1;
        busy_r <= 1'b0;
      end
    end
  end

  // ********************************
  // event injection
  // ********************************
  // live status bits are not driven here, only event flags
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      event_load <= 1'b0;
      event_value <= '0;
    end else if (clk_en) begin
      event_load <= wr_inject;
      if (wr_inject) begin
        event_value <= reg_wdata[sfe_pkg::SFE_B_PWR:sfe_pkg::SFE_B_CSTS];
      end
    end
  end

  // ********************************
  // control register
  // ********************************
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r <= sfe_pkg::SFE_CTRL_RST;
    end else if (wr_ctrl) begin
      // masking here keeps the reserved bit at zero without a second store
      ctrl_r <= reg_wdata[sfe_pkg::SFE_B_STOP:sfe_pkg::SFE_B_VPP_LO] &
        sfe_pkg::SFE_CTRL_WMASK;
    end
  end

  // ********************************
  // voltage check and clock policy
  // ********************************
  // vcc codes: 0 off, 1 reserved, 2 high, 3 low, 4 x, 5 y
  logic allowed_nxt;
  always_comb begin
    allowed_nxt = 1'b0;
    case (ctrl_r[sfe_pkg::SFE_B_VCC_HI:sfe_pkg::SFE_B_VCC_LO])
      // power off is always a legal request
      sfe_pkg::SFE_VCC_OFF: allowed_nxt = 1'b1;
      sfe_pkg::SFE_VCC_HIGH: allowed_nxt = present_state.volt_support[0];
      sfe_pkg::SFE_VCC_LOW: allowed_nxt = present_state.volt_support[1];
      sfe_pkg::SFE_VCC_X: allowed_nxt = present_state.volt_support[2];
      sfe_pkg::SFE_VCC_Y: allowed_nxt = present_state.volt_support[3];
      // reserved codes are refused only for a cardbus card; other cards pass below
      default: allowed_nxt = 1'b0;
    endcase
    // 16-bit cards are checked elsewhere; only cardbus is gated here
    if (!present_state.cardbus_detected_flag) begin
      allowed_nxt = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      vcc_request <= sfe_pkg::SFE_VCC_OFF;
      vpp_request <= sfe_pkg::SFE_VCC_OFF;
      vcc_request_allowed <= 1'b1;
      card_clk_stop_allowed <= 1'b0;
    end else if (clk_en) begin
      vcc_request_allowed <= allowed_nxt;
      // a refused request is turned into power off, never passed on
      vcc_request <= allowed_nxt ? ctrl_r[sfe_pkg::SFE_B_VCC_HI:sfe_pkg::SFE_B_VCC_LO] :
        sfe_pkg::SFE_VCC_OFF;
      vpp_request <= ctrl_r[sfe_pkg::SFE_B_VPP_HI:sfe_pkg::SFE_B_VPP_LO];
      card_clk_stop_allowed <= socket_idle &&
        (ctrl_r[sfe_pkg::SFE_B_STOP] || host_clk_stopping);
    end
  end

  // ********************************
  // assertions: register access
  // ********************************

  // injection word has no readable state
  a_inject_reads_zero: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (clk_en && reg_rd && reg_addr == sfe_pkg::SFE_OFF_INJECT) |=> reg_rdata == 32'h0)
    else $error("injection register read nonzero");

  // control read shows the stored byte with upper bits zero
  a_ctrl_read_value: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (clk_en && reg_rd && reg_addr == sfe_pkg::SFE_OFF_CTRL) |=>
      reg_rdata == {24'h00_0000, $past(ctrl_r)})
    else $error("control readback wrong");

  // only writable control bits take the written value
  a_ctrl_write_masked: assert property (@(posedge sys_clk) disable iff (!rst_b)
    wr_ctrl |=> ctrl_r == ($past(reg_wdata[sfe_pkg::SFE_B_STOP:sfe_pkg::SFE_B_VPP_LO]) &
      sfe_pkg::SFE_CTRL_WMASK))
    else $error("control write wrong");

  // reserved control bit never holds a one
  a_ctrl_reserved_zero: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ctrl_r[sfe_pkg::SFE_B_CTRL_RSVD] == 1'b0)
    else $error("control reserved bit set");

  // ********************************
  // assertions: clock enable freeze
  // ********************************

  // socket status holds while frozen
  a_freeze_state_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !clk_en |=> $stable(present_state))
    else $error("state moved while frozen");

  // control byte holds while frozen
  a_freeze_ctrl_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !clk_en |=> $stable(ctrl_r))
    else $error("control moved while frozen");

  // read data holds while frozen
  a_freeze_rdata_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !clk_en |=> $stable(reg_rdata))
    else $error("read data moved while frozen");

  // ********************************
  // assertions: injection
  // ********************************

  // any forced voltage support bit cuts socket power control
  a_volt_disables_power: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (wr_inject && |reg_wdata[sfe_pkg::SFE_B_VY:sfe_pkg::SFE_B_VL]) |=> !power_ctrl_enable)
    else $error("power control stayed on");

  // voltage support field follows the written bits
  a_volt_loaded: assert property (@(posedge sys_clk) disable iff (!rst_b)
    wr_inject |=> present_state.volt_support ==
      $past(reg_wdata[sfe_pkg::SFE_B_VY:sfe_pkg::SFE_B_VL]))
    else $error("voltage support wrong");

  // invalid voltage request flag follows its bit
  a_badv_loaded: assert property (@(posedge sys_clk) disable iff (!rst_b)
    wr_inject |=> present_state.invalid_voltage_request_flag ==
      $past(reg_wdata[sfe_pkg::SFE_B_BADV]))
    else $error("invalid voltage flag wrong");

  // data loss flag follows its bit
  a_loss_loaded: assert property (@(posedge sys_clk) disable iff (!rst_b)
    wr_inject |=> present_state.possible_data_loss_flag ==
      $past(reg_wdata[sfe_pkg::SFE_B_LOSS]))
    else $error("data loss flag wrong");

  // unrecognized card flag follows its bit
  a_unrec_loaded: assert property (@(posedge sys_clk) disable iff (!rst_b)
    wr_inject |=> present_state.unrecognized_card_flag ==
      $past(reg_wdata[sfe_pkg::SFE_B_UNREC]))
    else $error("unrecognized flag wrong");

  // cardbus detect flag follows its bit
  a_cb_loaded: assert property (@(posedge sys_clk) disable iff (!rst_b)
    wr_inject |=> present_state.cardbus_detected_flag == $past(reg_wdata[sfe_pkg::SFE_B_CB]))
    else $error("cardbus flag wrong");

  // narrow card detect flag follows its bit
  a_narrow_loaded: assert property (@(posedge sys_clk) disable iff (!rst_b)
    wr_inject |=> present_state.narrow_card_detected_flag ==
      $past(reg_wdata[sfe_pkg::SFE_B_NARROW]))
    else $error("narrow card flag wrong");

  // event flags leave with a load pulse
  a_event_loaded: assert property (@(posedge sys_clk) disable iff (!rst_b)
    wr_inject |=> event_load &&
      event_value == $past(reg_wdata[sfe_pkg::SFE_B_PWR:sfe_pkg::SFE_B_CSTS]))
    else $error("event value wrong");

  // no load pulse without an injection write
  a_event_one_cycle: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (clk_en && !wr_inject) |=> !event_load)
    else $error("event load without write");

  // status only moves on a write or a finished probe
  a_state_holds_idle: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (clk_en && !wr_inject && !busy_r) |=> $stable(present_state))
    else $error("state moved without cause");

  // ********************************
  // assertions: interrogation
  // ********************************

  // trigger bit launches a probe
  a_trigger_starts_probe: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (wr_inject && reg_wdata[sfe_pkg::SFE_B_REINT]) |=> interrogate_start)
    else $error("interrogation not started");

  // trigger bit marks a probe in flight
  a_busy_set: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (wr_inject && reg_wdata[sfe_pkg::SFE_B_REINT]) |=> busy_r)
    else $error("probe not marked busy");

  // start is a single-cycle pulse
  a_start_one_cycle: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (clk_en && interrogate_start && !(wr_inject && reg_wdata[sfe_pkg::SFE_B_REINT])) |=>
      !interrogate_start)
    else $error("start pulse too long");

  // finished probe refreshes the socket status
  a_probe_loads_state: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (clk_en && !wr_inject && busy_r && interrogate_done) |=>
      present_state == $past(interrogate_result))
    else $error("probe result not loaded");

  // finished probe gives power control back
  a_probe_reenables: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (clk_en && !wr_inject && busy_r && interrogate_done) |=> power_ctrl_enable)
    else $error("power not reenabled");

  // ********************************
  // assertions: power and clock policy
  // ********************************

  // power off is always accepted
  a_vcc_off_allowed: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (clk_en && ctrl_r[sfe_pkg::SFE_B_VCC_HI:sfe_pkg::SFE_B_VCC_LO] == sfe_pkg::SFE_VCC_OFF)
      |=> vcc_request_allowed && vcc_request == sfe_pkg::SFE_VCC_OFF)
    else $error("power off refused");

  // high voltage refused for a cardbus card without high support
  a_high_refused: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (clk_en && present_state.cardbus_detected_flag && !present_state.volt_support[0] &&
      ctrl_r[sfe_pkg::SFE_B_VCC_HI:sfe_pkg::SFE_B_VCC_LO] == sfe_pkg::SFE_VCC_HIGH)
      |=> !vcc_request_allowed && vcc_request == sfe_pkg::SFE_VCC_OFF)
    else $error("high voltage not refused");

  // low voltage refused for a cardbus card without low support
  a_low_refused: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (clk_en && present_state.cardbus_detected_flag && !present_state.volt_support[1] &&
      ctrl_r[sfe_pkg::SFE_B_VCC_HI:sfe_pkg::SFE_B_VCC_LO] == sfe_pkg::SFE_VCC_LOW)
      |=> !vcc_request_allowed && vcc_request == sfe_pkg::SFE_VCC_OFF)
    else $error("low voltage not refused");

  // programming voltage request passes straight through
  a_vpp_follows: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en |=> vpp_request == $past(ctrl_r[sfe_pkg::SFE_B_VPP_HI:sfe_pkg::SFE_B_VPP_LO]))
    else $error("vpp request wrong");

  // policy zero needs the host clock to be stopping too
  a_clk_stop_policy: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (clk_en && !ctrl_r[sfe_pkg::SFE_B_STOP] && !host_clk_stopping) |=> !card_clk_stop_allowed)
    else $error("clock stop allowed wrongly");

  // policy one lets an idle socket stop its clock
  a_clk_stop_free: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (clk_en && ctrl_r[sfe_pkg::SFE_B_STOP] && socket_idle) |=> card_clk_stop_allowed)
    else $error("clock stop not allowed");

  // a busy socket never stops its clock
  a_clk_stop_busy: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (clk_en && !socket_idle) |=> !card_clk_stop_allowed)
    else $error("clock stop while busy");
endmodule : sfe_socket_regs

`default_nettype wire
